// >>> logic/csk_pkg.sv
// Package for the compare-with-skip execution unit
package csk_pkg;
    // Opcode fields of the compare instructions
    localparam logic [6:0] CSK_OP_GREATER = 7'h32;
    localparam logic [6:0] CSK_OP_LESS = 7'h30;
    localparam int CSK_OP_MSB = 15;
    localparam int CSK_OP_LSB = 9;
    localparam int CSK_ABIT = 8;
    // Highest file address that uses indexed literal offset mode
    localparam logic [7:0] CSK_INDEXED_MAX = 8'h5F;
    // Access bank split: addresses below 0x60 in bank zero, the rest in the top bank
    localparam logic [7:0] CSK_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] CSK_BANK_LOW = 4'h0;
    localparam logic [3:0] CSK_BANK_HIGH = 4'hF;
    // No-operation cycles after a skip
    localparam logic [1:0] CSK_SKIP_ONE = 2'h1;
    localparam logic [1:0] CSK_SKIP_TWO = 2'h2;

    typedef enum logic [1:0] {
        CSK_IDLE = 2'b00,
        CSK_READ = 2'b01,
        CSK_FLUSH = 2'b10
    } csk_state_type;
endpackage : csk_pkg

// >>> logic/csk_address.sv
// Data-memory address selection for the compare instructions
`timescale 1ns/1ps
`default_nettype none
module csk_address
    import csk_pkg::*;
(
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic extended_on,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    output logic [11:0] data_addr,
    output logic indexed
);
    // Pick bank-select, access bank, or indexed literal offset
    always_comb begin
        indexed = 1'b0;
        if (access_sel) begin
            data_addr = {bank_select_register, file_addr};
        end else if (extended_on && file_addr <= CSK_INDEXED_MAX) begin
            indexed = 1'b1;
            data_addr = index_base + {4'h0, file_addr};
        end else if (file_addr < CSK_ACCESS_SPLIT) begin
            data_addr = {CSK_BANK_LOW, file_addr};
        end else begin
            data_addr = {CSK_BANK_HIGH, file_addr};
        end
    end
endmodule // csk_address
`default_nettype wire

// >>> logic/csk_unit.sv
// Compare-with-skip execution unit for the 8-bit core
`timescale 1ns/1ps
`default_nettype none
module csk_unit
    import csk_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic NEXT_TWO_WORD,
    input wire logic EXTENDED_ON,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] WORKING_REGISTER,
    input wire logic [7:0] FILE_DATA,
    output logic [11:0] FILE_ADDR,
    output logic FILE_READ,
    output logic INDEXED_MODE,
    output logic DISCARD_FETCH,
    output logic BUSY,
    output logic DONE
);
    typedef struct packed {
        csk_state_type state;
        logic is_greater;
        logic two_word;
        logic [1:0] flush_left;
        logic [11:0] addr;
        logic rd;
        logic indexed;
        logic discard;
        logic busy;
        logic done;
    } csk_regs_type;

    csk_regs_type r_q;
    csk_regs_type r_d;
    logic [11:0] sel_addr;
    logic sel_indexed;
    logic is_cmp;
    logic take_skip;

    // Operand address, shared by both compare variants
    csk_address u_addr (
        .file_addr(INSTR_WORD[7:0]),
        .access_sel(INSTR_WORD[CSK_ABIT]),
        .extended_on(EXTENDED_ON),
        .bank_select_register(BANK_SELECT_REGISTER),
        .index_base(INDEX_BASE),
        .data_addr(sel_addr),
        .indexed(sel_indexed)
    );

    assign is_cmp = INSTR_VALID &&
        (INSTR_WORD[CSK_OP_MSB:CSK_OP_LSB] == CSK_OP_GREATER ||
         INSTR_WORD[CSK_OP_MSB:CSK_OP_LSB] == CSK_OP_LESS);

    // Unsigned compare; nothing is written back anywhere
    always_comb begin
        if (r_q.is_greater) begin
            take_skip = FILE_DATA > WORKING_REGISTER;
        end else begin
            take_skip = FILE_DATA < WORKING_REGISTER;
        end
    end

    // Next-state logic; outputs are registered copies of the state
    always_comb begin
        r_d = r_q;
        r_d.rd = 1'b0;
        r_d.done = 1'b0;
        r_d.discard = 1'b0;
        case (r_q.state)
            CSK_IDLE: begin
                if (is_cmp) begin
                    r_d.state = CSK_READ;
                    r_d.is_greater = INSTR_WORD[CSK_OP_MSB:CSK_OP_LSB]
                        == CSK_OP_GREATER;
                    r_d.two_word = NEXT_TWO_WORD;
                    r_d.addr = sel_addr;
                    r_d.indexed = sel_indexed;
                    r_d.rd = 1'b1;
                    r_d.busy = 1'b1;
                end
            end
            CSK_READ: begin
                if (take_skip) begin
                    r_d.state = CSK_FLUSH;
                    r_d.discard = 1'b1;
                    r_d.flush_left = r_q.two_word ? CSK_SKIP_TWO
                        : CSK_SKIP_ONE;
                end else begin
                    r_d.state = CSK_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            CSK_FLUSH: begin
                // Each nop cycle holds the core without side effects
                r_d.discard = 1'b1;
                r_d.flush_left = r_q.flush_left - CSK_SKIP_ONE;
                if (r_q.flush_left == CSK_SKIP_ONE) begin
                    r_d.state = CSK_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                    r_d.discard = 1'b0;
                end
            end
            default: begin
                r_d.state = CSK_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign FILE_ADDR = r_q.addr;
    assign FILE_READ = r_q.rd;
    assign INDEXED_MODE = r_q.indexed;
    assign DISCARD_FETCH = r_q.discard;
    assign BUSY = r_q.busy;
    assign DONE = r_q.done;

    // Skip decision leads to a flush on the next edge
    property p_skip_flush;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_READ && take_skip) |=> DISCARD_FETCH;
    endproperty
    a_skip_flush: assert property (p_skip_flush)
        else $error("skip did not flush");

    // No skip finishes at once without discard
    property p_no_skip;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_READ && !take_skip) |=> DONE && !DISCARD_FETCH;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("no-skip path wrong");

    // Two-word skip: two discard cycles then done
    property p_two_word;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_READ && take_skip && r_q.two_word)
            |=> DISCARD_FETCH ##1 DISCARD_FETCH ##1 DONE;
    endproperty
    a_two_word: assert property (p_two_word)
        else $error("two-word skip length wrong");

    // Greater variant flushes exactly when the byte is above, unsigned
    property p_greater;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_READ && r_q.is_greater)
            |=> DISCARD_FETCH == ($past(FILE_DATA)
                > $past(WORKING_REGISTER));
    endproperty
    a_greater: assert property (p_greater)
        else $error("greater compare wrong");

    // Less variant flushes exactly when the byte is below, unsigned
    property p_less;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_READ && !r_q.is_greater)
            |=> DISCARD_FETCH == ($past(FILE_DATA)
                < $past(WORKING_REGISTER));
    endproperty
    a_less: assert property (p_less)
        else $error("less compare wrong");

    // Bank-select addressing when access bit is one
    property p_bank_sel;
        @(posedge REF_CLK) disable iff (SRST)
        (r_q.state == CSK_IDLE && is_cmp && INSTR_WORD[CSK_ABIT])
            |=> FILE_ADDR[11:8] == $past(BANK_SELECT_REGISTER);
    endproperty
    a_bank_sel: assert property (p_bank_sel)
        else $error("bank select not used");

    // Indexed mode only for low addresses in extended mode
    property p_indexed;
        @(posedge REF_CLK) disable iff (SRST)
        FILE_READ |-> INDEXED_MODE == ($past(EXTENDED_ON)
            && !$past(INSTR_WORD[CSK_ABIT])
            && $past(INSTR_WORD[7:0]) <= CSK_INDEXED_MAX);
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed mode wrong");

    // Access bank when access bit zero and not indexed
    property p_access;
        @(posedge REF_CLK) disable iff (SRST)
        (FILE_READ && !INDEXED_MODE && !$past(INSTR_WORD[CSK_ABIT]))
            |-> FILE_ADDR[7:0] == $past(INSTR_WORD[7:0])
                && FILE_ADDR[11:8] == (($past(INSTR_WORD[7:0])
                < CSK_ACCESS_SPLIT) ? CSK_BANK_LOW : CSK_BANK_HIGH);
    endproperty
    a_access: assert property (p_access)
        else $error("access bank not used");

    // Busy ends within three cycles of a read
    property p_bounded;
        @(posedge REF_CLK) disable iff (SRST)
        FILE_READ |-> ##[1:3] DONE;
    endproperty
    a_bounded: assert property (p_bounded)
        else $error("compare did not finish");
endmodule // csk_unit
`default_nettype wire

// >>> testbench/csk_testbench.sv
// Self-checking testbench for the compare-with-skip execution unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import csk_pkg::*;
    typedef struct packed {
        logic gt;
        logic acc;
        logic ext;
        logic two;
        logic [3:0] bank;
        logic [7:0] f;
        logic [7:0] w;
        logic [7:0] d;
    } csk_row_type;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic valid = 1'b0;
    logic two = 1'b0;
    logic ext = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic [11:0] base = 12'hFA0;
    logic [7:0] work_reg = 8'h00;
    logic [7:0] fdata = 8'h00;
    logic [11:0] file_addr;
    logic file_read, indexed, discard, busy, done;
    int errors = 0;
    int checks = 0;
    // Unsigned edges, equality, both access paths and the indexed boundary
    csk_row_type rows [9] = '{
        '{1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 8'h10, 8'h05, 8'h06},
        '{1'b1, 1'b1, 1'b0, 1'b1, 4'h7, 8'hFF, 8'h80, 8'h7F},
        '{1'b1, 1'b0, 1'b0, 1'b1, 4'h2, 8'h20, 8'h7F, 8'h80},
        '{1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 8'h60, 8'h44, 8'h44},
        '{1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 8'h5F, 8'h80, 8'h7F},
        '{1'b0, 1'b0, 1'b1, 1'b1, 4'h5, 8'h60, 8'h01, 8'h00},
        '{1'b0, 1'b1, 1'b1, 1'b0, 4'h9, 8'h00, 8'h00, 8'h00},
        '{1'b0, 1'b1, 1'b0, 1'b1, 4'hA, 8'hC3, 8'h00, 8'hFF},
        '{1'b1, 1'b0, 1'b1, 1'b0, 4'h1, 8'h00, 8'hFF, 8'h00}};

    csk_unit DUT (.REF_CLK(ref_clk), .SRST(srst), .INSTR_VALID(valid),
        .INSTR_WORD(word), .NEXT_TWO_WORD(two), .EXTENDED_ON(ext),
        .BANK_SELECT_REGISTER(bank_sel), .INDEX_BASE(base),
        .WORKING_REGISTER(work_reg), .FILE_DATA(fdata), .FILE_ADDR(file_addr),
        .FILE_READ(file_read), .INDEXED_MODE(indexed),
        .DISCARD_FETCH(discard), .BUSY(busy), .DONE(done));

    always #25 ref_clk = ~ref_clk;

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_addr(logic [11:0] got, logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(logic got, logic exp);
        chk_addr({11'h000, got}, {11'h000, exp});
    endtask

    task automatic chk_cnt(int got, int exp);
        chk_addr(got[11:0], exp[11:0]);
    endtask

    // Operand address worked out from the access bit and mode
    function automatic logic [11:0] exp_addr(csk_row_type r);
        if (r.acc)
            return {r.bank, r.f};
        if (r.ext && r.f <= CSK_INDEXED_MAX)
            return base + {4'h0, r.f};
        return {(r.f < CSK_ACCESS_SPLIT) ? CSK_BANK_LOW : CSK_BANK_HIGH, r.f};
    endfunction

    // One compare; poke offers a second instruction while busy
    task automatic run(csk_row_type r, logic poke);
        int n;
        int nops;
        logic skip;
        skip = r.gt ? (r.d > r.w) : (r.d < r.w);
        word = {r.gt ? CSK_OP_GREATER : CSK_OP_LESS, r.acc, r.f};
        two = r.two;
        ext = r.ext;
        bank_sel = r.bank;
        work_reg = r.w;
        fdata = r.d;
        valid = 1'b1;
        @(posedge ref_clk);
        #1;
        word = {CSK_OP_LESS, 1'b1, 8'h77};
        valid = poke;
        chk_bit(file_read & busy, 1'b1);
        chk_bit(indexed, !r.acc && r.ext && r.f <= CSK_INDEXED_MAX);
        n = 1;
        nops = 0;
        while (done !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
            // Leave valid alone on the last edge, so that the next
            // request may raise it in this step without a double drive
            if (done !== 1'b1)
                valid = 1'b0;
            if (discard === 1'b1)
                nops++;
        end
        chk_cnt(n, skip ? (r.two ? 4 : 3) : 2);
        chk_cnt(nops, skip ? (r.two ? 2 : 1) : 0);
        chk_addr(file_addr, exp_addr(r));
        chk_bit(busy | file_read, 1'b0);
    endtask

    // Watchdog, far beyond the roughly 42 cycles the tests need
    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk_bit(busy | done | file_read | discard, 1'b0);
        $display("reset done");
        // Rows issued back to back, each in the cycle of the last DONE
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
            $display("row %0d done", i);
        end
        run(rows[2], 1'b1);
        $display("busy refusal done");
        word = {7'h33, 9'h000};
        valid = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_bit(file_read | busy, 1'b0);
        $display("foreign opcode done");
        run(rows[0], 1'b0);
        word = {CSK_OP_GREATER, 1'b1, 8'h10};
        fdata = 8'hFF;
        valid = 1'b1;
        @(posedge ref_clk);
        #1;
        valid = 1'b0;
        srst = 1'b1;
        @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk_bit(busy | done | file_read | discard | indexed, 1'b0);
        run(rows[4], 1'b0);
        $display("mid-run reset done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
